// file: rtl/sras_consts.svh
`ifndef SRAS_CONSTS_SVH
`define SRAS_CONSTS_SVH
// control register offsets inside the register space
`define CTRL_A_ADDR 8'h12
`define CTRL_B_ADDR 8'h13
// field positions
`define AUTO_INC_BIT 2
`define THREE_WIRE_BIT 3
`define I2C_OFF_BIT 2
// reset values
`define CTRL_A_RST 8'h00
`define CTRL_B_RST 8'h00
`define PINS_IDLE 4'hf
// fixed upper six bits of the slave address
`define SLAVE_ADDR_HI 6'h35
// pin positions inside the synchroniser vectors
`define PIN_CS 0
`define PIN_SCL 1
`define PIN_SDA 2
`define PIN_ADR 3
// bit counts
`define BYTE_BITS 4'h8
`define SPI_LAST_BIT 3'h7
`endif

// file: rtl/sras_pkg.sv
package sras_pkg;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_SUB, I_WDATA, I_RDATA, I_IGNORE} i2c_state_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] filt;
		logic [3:0] filtD;
	} pin_sync_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_t;

	typedef struct packed {
		i2c_state_t i2cState;
		logic [3:0] i2cCnt;
		logic i2cInAck;
		logic i2cRead;
		logic masterAck;
		logic [7:0] shiftIn;
		logic [7:0] shiftOut;
		logic [7:0] regAddr;
		logic [7:0] ctrlA;
		logic [7:0] ctrlB;
		logic [2:0] spiCnt;
		logic spiCmdDone;
		logic spiRead;
		logic spiDriving;
		logic sdaOut;
		logic sdaEnN;
		logic sdoOut;
		logic sdoEnN;
		pin_sync_t pins;
	} slave_state_t;
endpackage

// file: rtl/reg_store.sv
`timescale 1ns/1ps
// register space; read data is registered, one cycle behind the address
module reg_store #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// no reset: contents are whatever the host last wrote
	always_ff @(posedge clk) begin
		if (ce) begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule // reg_store

// file: rtl/serial_register_access_slave.sv
// Notes on behaviour
// - chip select high means I2C, low SPI
// - SPI works in clock mode 0 and 3
// - I2C standard and fast mode up to 400 kHz
// - I2C off bit at 13h disables I2C
// - start: data falls while clock high, busy
// - stop: data rises while clock high
// - seven address bits then direction bit
// - address 110101 plus address pin level
// - addressed receiver acknowledges by holding data low
// - write: pointer byte then acknowledged data bytes
// - auto-increment bit at 12h advances address
// - auto-increment clear keeps the same address
// - I2C bytes MSB first, unlimited count
// - clock held low makes transmitter wait
// - unmatched address leaves data line high
// - outputs change on falling, sampled on rising
// - sixteen pulses plus eight per extra byte
// - bits counted from first falling edge
// - bit0 direction, bits1-7 address, then data
// - read drives at bit 8; 3-wire on data
`timescale 1ns/1ps
`include "sras_consts.svh"
module serial_register_access_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic chipSelect,
	input wire logic serialPortClock,
	input wire logic dataPinIn,
	output logic dataPinOut,
	output logic dataPinOeN,
	input wire logic dataOutOrAddressPinIn,
	output logic dataOutOrAddressPinOut,
	output logic dataOutOrAddressPinOeN,
	output logic autoIncrement,
	output logic threeWireSelect,
	output logic i2cOff
);
	sras_pkg::slave_state_t st_r;
	sras_pkg::slave_state_t st_nxt;
	sras_pkg::reg_write_t wr;
	logic [7:0] memData;
	logic csLow, sclHigh, sclRise, sclFall, sdaIn, startEv, stopEv, i2cEn;
	logic spiRise, spiFall, autoInc, threeWire;
	logic [6:0] ownAddr;

	// control bytes live in flops so their bits can steer logic directly
	function automatic logic [7:0] read_byte(input logic [7:0] addr,
		input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] md);
		if (addr == `CTRL_A_ADDR) begin
			return ca;
		end else if (addr == `CTRL_B_ADDR) begin
			return cb;
		end else begin
			return md;
		end
	endfunction

	reg_store #(.ADDR_W(8), .DATA_W(8)) i_reg_store (
		.clk(clk),
		.ce(ce),
		.wrEn(wr.en),
		.wrAddr(wr.addr),
		.wrData(wr.data),
		.rdAddr(st_r.regAddr),
		.rdData(memData)
	);

	// pin events from the filtered copies only, never from the first stage
	assign csLow = !st_r.pins.filt[`PIN_CS];
	assign sclHigh = st_r.pins.filt[`PIN_SCL] & st_r.pins.filtD[`PIN_SCL];
	assign sclRise = st_r.pins.filt[`PIN_SCL] & !st_r.pins.filtD[`PIN_SCL];
	assign sclFall = !st_r.pins.filt[`PIN_SCL] & st_r.pins.filtD[`PIN_SCL];
	assign sdaIn = st_r.pins.filt[`PIN_SDA];
	assign startEv = sclHigh & !sdaIn & st_r.pins.filtD[`PIN_SDA];
	assign stopEv = sclHigh & sdaIn & !st_r.pins.filtD[`PIN_SDA];
	assign i2cEn = !csLow & !st_r.ctrlB[`I2C_OFF_BIT];
	assign spiRise = csLow & !st_r.pins.filtD[`PIN_CS] & sclRise;
	assign spiFall = csLow & !st_r.pins.filtD[`PIN_CS] & sclFall;
	assign autoInc = st_r.ctrlA[`AUTO_INC_BIT];
	assign threeWire = st_r.ctrlA[`THREE_WIRE_BIT];
	assign ownAddr = {`SLAVE_ADDR_HI, st_r.pins.filt[`PIN_ADR]};

	// next-state logic for the whole port
	always_comb begin
		logic [7:0] b;
		b = '0;
		st_nxt = st_r;
		wr = '0;
		// three-stage sampling; 8+ clocks per bit even in fast mode
		st_nxt.pins.s1 = {dataOutOrAddressPinIn, dataPinIn, serialPortClock, chipSelect};
		st_nxt.pins.s2 = st_r.pins.s1;
		st_nxt.pins.s3 = st_r.pins.s2;
		for (int i = 0; i < 4; i++) begin
			if (st_r.pins.s2[i] == st_r.pins.s3[i]) begin
				st_nxt.pins.filt[i] = st_r.pins.s3[i];
			end
		end
		st_nxt.pins.filtD = st_r.pins.filt;
		if (!csLow) begin
			// I2C side; SPI frame state is dropped while select is high
			st_nxt.spiCnt = '0;
			st_nxt.spiCmdDone = 1'b0;
			st_nxt.spiDriving = 1'b0;
			st_nxt.sdoEnN = 1'b1; // pin reads back the address strap
			st_nxt.sdaOut = 1'b0; // open drain: only ever pull low
			if (!i2cEn || !st_r.pins.filtD[`PIN_CS]) begin // select rising ends any 3-wire drive
				st_nxt.i2cState = sras_pkg::I_IDLE;
				st_nxt.sdaEnN = 1'b1;
			end else if (startEv) begin
				st_nxt.i2cState = sras_pkg::I_ADDR; // also repeated start
				st_nxt.i2cCnt = '0;
				st_nxt.i2cInAck = 1'b0;
				st_nxt.sdaEnN = 1'b1;
			end else if (stopEv) begin
				st_nxt.i2cState = sras_pkg::I_IDLE;
				st_nxt.i2cInAck = 1'b0;
				st_nxt.sdaEnN = 1'b1;
			end else if (st_r.i2cState != sras_pkg::I_IDLE &&
				st_r.i2cState != sras_pkg::I_IGNORE) begin
				if (sclRise) begin
					if (st_r.i2cCnt < `BYTE_BITS) begin
						st_nxt.shiftIn = {st_r.shiftIn[6:0], sdaIn}; // msb first
						st_nxt.i2cCnt = st_r.i2cCnt + 4'h1;
					end else if (st_r.i2cState == sras_pkg::I_RDATA) begin
						st_nxt.masterAck = !sdaIn;
					end
				end else if (sclFall) begin
					if (st_r.i2cCnt == `BYTE_BITS && !st_r.i2cInAck) begin
						st_nxt.i2cInAck = 1'b1;
						case (st_r.i2cState)
							sras_pkg::I_ADDR: begin
								if (st_r.shiftIn[7:1] == ownAddr) begin
									st_nxt.sdaEnN = 1'b0;
									st_nxt.i2cRead = st_r.shiftIn[0];
								end else begin
									st_nxt.i2cState = sras_pkg::I_IGNORE;
									st_nxt.i2cInAck = 1'b0;
								end
							end
							sras_pkg::I_SUB: begin
								st_nxt.regAddr = st_r.shiftIn;
								st_nxt.sdaEnN = 1'b0;
							end
							sras_pkg::I_WDATA: begin
								wr = '{en: 1'b1, addr: st_r.regAddr, data: st_r.shiftIn};
								if (autoInc) begin
									st_nxt.regAddr = st_r.regAddr + 8'h01;
								end
								st_nxt.sdaEnN = 1'b0;
							end
							default: begin
								st_nxt.sdaEnN = 1'b1; // master acknowledges here
							end
						endcase
					end else if (st_r.i2cCnt == `BYTE_BITS) begin
						// acknowledge clock over: release and pick the next byte
						st_nxt.i2cInAck = 1'b0;
						st_nxt.i2cCnt = '0;
						st_nxt.sdaEnN = 1'b1;
						case (st_r.i2cState)
							sras_pkg::I_ADDR: begin
								st_nxt.i2cState = st_r.i2cRead ? sras_pkg::I_RDATA : sras_pkg::I_SUB;
							end
							sras_pkg::I_SUB: begin
								st_nxt.i2cState = sras_pkg::I_WDATA;
							end
							sras_pkg::I_RDATA: begin
								if (!st_r.masterAck) begin
									st_nxt.i2cState = sras_pkg::I_IGNORE; // last byte
								end
							end
							default: begin
								st_nxt.i2cState = st_r.i2cState;
							end
						endcase
						if (st_nxt.i2cState == sras_pkg::I_RDATA) begin
							b = read_byte(st_r.regAddr, st_r.ctrlA, st_r.ctrlB, memData);
							st_nxt.sdaEnN = b[7];
							st_nxt.shiftOut = {b[6:0], 1'b0};
							st_nxt.masterAck = 1'b0;
							if (autoInc) begin
								st_nxt.regAddr = st_r.regAddr + 8'h01;
							end
						end
					end else if (st_r.i2cState == sras_pkg::I_RDATA) begin
						// bits move only on falling edges, so a held-low clock stalls us
						st_nxt.sdaEnN = st_r.shiftOut[7];
						st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
					end
				end
			end
		end else begin
			// SPI side; I2C is parked while select is low
			st_nxt.i2cState = sras_pkg::I_IDLE;
			st_nxt.i2cInAck = 1'b0;
			if (st_r.pins.filtD[`PIN_CS]) begin
				// select just fell: fresh frame, either clock idle level
				st_nxt.spiCnt = '0;
				st_nxt.spiCmdDone = 1'b0;
				st_nxt.spiRead = 1'b0;
				st_nxt.spiDriving = 1'b0;
			end else if (sclRise) begin
				b = {st_r.shiftIn[6:0], sdaIn}; // sample on rising
				st_nxt.shiftIn = b;
				st_nxt.spiCnt = st_r.spiCnt + 3'h1; // 8 pulses per byte
				if (st_r.spiCnt == `SPI_LAST_BIT) begin
					if (!st_r.spiCmdDone) begin
						st_nxt.spiCmdDone = 1'b1;
						st_nxt.spiRead = b[7];
						st_nxt.regAddr = {1'b0, b[6:0]};
					end else if (!st_r.spiRead) begin
						wr = '{en: 1'b1, addr: st_r.regAddr, data: b};
						if (autoInc) begin
							st_nxt.regAddr = st_r.regAddr + 8'h01;
						end
					end
				end
			end else if (sclFall && st_r.spiCmdDone && st_r.spiRead) begin
				if (st_r.spiCnt == 3'h0) begin
					// first falling edge of a byte starts its msb
					b = read_byte(st_r.regAddr, st_r.ctrlA, st_r.ctrlB, memData);
					st_nxt.sdoOut = b[7];
					st_nxt.shiftOut = {b[6:0], 1'b0};
					st_nxt.spiDriving = 1'b1;
					if (autoInc) begin
						st_nxt.regAddr = st_r.regAddr + 8'h01;
					end
				end else begin
					st_nxt.sdoOut = st_r.shiftOut[7];
					st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
				end
			end
			// same bit goes to whichever pin the wire mode selects
			st_nxt.sdaOut = st_nxt.sdoOut;
			st_nxt.sdoEnN = !(st_nxt.spiDriving && !threeWire);
			st_nxt.sdaEnN = !(st_nxt.spiDriving && threeWire);
		end
		// writes to the control bytes also land in their flops
		if (wr.en) begin
			if (wr.addr == `CTRL_A_ADDR) begin
				st_nxt.ctrlA = wr.data;
			end else if (wr.addr == `CTRL_B_ADDR) begin
				st_nxt.ctrlB = wr.data;
			end
		end
	end

	// single state register; clock enable freezes everything
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.i2cState <= sras_pkg::I_IDLE;
			st_r.ctrlA <= `CTRL_A_RST;
			st_r.ctrlB <= `CTRL_B_RST;
			st_r.sdaEnN <= 1'b1;
			st_r.sdoEnN <= 1'b1;
			st_r.pins <= {5{`PINS_IDLE}};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign dataPinOut = st_r.sdaOut;
	assign dataPinOeN = st_r.sdaEnN;
	assign dataOutOrAddressPinOut = st_r.sdoOut;
	assign dataOutOrAddressPinOeN = st_r.sdoEnN;
	assign autoIncrement = st_r.ctrlA[`AUTO_INC_BIT];
	assign threeWireSelect = st_r.ctrlA[`THREE_WIRE_BIT];
	assign i2cOff = st_r.ctrlB[`I2C_OFF_BIT];

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);
	logic addrDone;
	assign addrDone = i2cEn && !startEv && !stopEv && sclFall && !st_r.i2cInAck &&
		st_r.i2cState == sras_pkg::I_ADDR && st_r.i2cCnt == `BYTE_BITS;

	property p_spi_parks_i2c;
		csLow |=> st_r.i2cState == sras_pkg::I_IDLE;
	endproperty
	a_spi_parks_i2c: assert property (p_spi_parks_i2c) else $error("i2c busy in spi");
	property p_i2c_off;
		st_r.ctrlB[`I2C_OFF_BIT] |=> st_r.i2cState == sras_pkg::I_IDLE;
	endproperty
	a_i2c_off: assert property (p_i2c_off) else $error("i2c active while off");
	property p_start;
		(i2cEn && startEv) |=> st_r.i2cState == sras_pkg::I_ADDR && st_r.i2cCnt == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_stop;
		(i2cEn && stopEv) |=> st_r.i2cState == sras_pkg::I_IDLE && st_r.sdaEnN;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_addr_ack;
		(addrDone && st_r.shiftIn[7:1] == ownAddr) |=> !st_r.sdaEnN && st_r.i2cInAck;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
	property p_addr_nak;
		(addrDone && st_r.shiftIn[7:1] != ownAddr) |=>
			st_r.sdaEnN && st_r.i2cState == sras_pkg::I_IGNORE;
	endproperty
	a_addr_nak: assert property (p_addr_nak) else $error("foreign address acked");
	property p_spi_cmd;
		(spiRise && !st_r.spiCmdDone && st_r.spiCnt == `SPI_LAST_BIT) |=> st_r.spiCmdDone &&
			st_r.spiRead == $past(st_r.shiftIn[6]) && st_r.regAddr[7] == 1'b0;
	endproperty
	a_spi_cmd: assert property (p_spi_cmd) else $error("spi command misdecoded");
	property p_spi_drive;
		(spiFall && st_r.spiCmdDone && st_r.spiRead && st_r.spiCnt == 3'h0) |=>
			(threeWire ? !st_r.sdaEnN : !st_r.sdoEnN);
	endproperty
	a_spi_drive: assert property (p_spi_drive) else $error("read data not driven");
	property p_out_on_fall;
		(csLow && $changed(st_r.sdoOut)) |-> $past(sclFall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("moved off fall");
	property p_autoinc;
		(wr.en && autoInc) |=> st_r.regAddr == $past(st_r.regAddr) + 8'h01;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("address not advanced");
	property p_no_inc;
		(wr.en && !autoInc) |=> $stable(st_r.regAddr);
	endproperty
	a_no_inc: assert property (p_no_inc) else $error("address moved");

	c_i2c_write: cover property (wr.en && !csLow);
	c_i2c_read: cover property (st_r.i2cState == sras_pkg::I_RDATA && st_r.masterAck && sclFall);
	c_spi_read: cover property (spiFall && st_r.spiRead && !threeWire);
	c_spi_3wire: cover property (!st_r.sdaEnN && csLow);
endmodule // serial_register_access_slave

// file: verif/host_master.sv
`timescale 1ns/1ps
// behavioural host: masters the shared pins as I2C or SPI and reports each I2C byte and each SPI read data byte it saw
module host_master (
	input wire logic clk,
	input wire logic dataPinOut,
	input wire logic dataPinOeN,
	input wire logic dataOutOrAddressPinOut,
	input wire logic dataOutOrAddressPinOeN,
	output logic chipSelect,
	output logic serialPortClock,
	output logic dataPinIn,
	output logic dataOutOrAddressPinIn,
	output logic gotStb,
	output logic [8:0] gotVal
);
	logic sdaM;
	logic adrLevel;
	logic threeWire;
	int half;
	logic [7:0] txQ[$];
	// open-drain data wire with pull-up: whoever pulls low wins
	assign dataPinIn = (dataPinOeN | dataPinOut) & sdaM;
	// a released output pin falls back to the address strap level
	assign dataOutOrAddressPinIn = dataOutOrAddressPinOeN ? adrLevel : dataOutOrAddressPinOut;
	initial begin
		chipSelect = 1'b1; // select kept high for I2C
		serialPortClock = 1'b1;
		sdaM = 1'b1;
		adrLevel = 1'b1;
		threeWire = 1'b0;
		half = 32;
		gotStb = 1'b0;
		gotVal = 9'h000;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic report(input logic [8:0] v);
		gotVal = v;
		gotStb = 1'b1;
		tk(1);
		gotStb = 1'b0;
	endtask
	// one frame: command byte then n data bytes; sampled late in the high phase for latency
	task automatic spi(input logic rd, input logic [6:0] a, input int n, input logic m3);
		logic [7:0] b;
		tk(4);
		chipSelect = 1'b0; // low for the whole frame
		serialPortClock = m3; // mode 0 clock drops only once selected
		tk(4);
		for (int k = 0; k <= n; k++) begin
			b = (k == 0) ? {rd, a} : (rd ? 8'hff : txQ.pop_front());
			for (int i = 7; i >= 0; i--) begin
				serialPortClock = 1'b0; // first fall after select starts bit 0
				sdaM = b[i]; // change after the falling edge
				tk(4);
				serialPortClock = 1'b1;
				tk(4);
				b[i] = threeWire ? dataPinIn : dataOutOrAddressPinIn;
			end
			if (rd && k > 0) report({1'b0, b});
		end
		serialPortClock = m3;
		tk(4);
		sdaM = 1'b1;
		chipSelect = 1'b1;
		serialPortClock = 1'b1; // clock parked high while deselected
		tk(8);
	endtask
	task automatic i2cBit(input logic o, output logic s);
		tk(half / 2);
		sdaM = o;
		tk(half / 2);
		serialPortClock = 1'b1;
		tk(half);
		s = dataPinIn;
		serialPortClock = 1'b0;
	endtask
	// start and repeated start: data falls while clock high
	task automatic i2cSt();
		sdaM = 1'b1;
		tk(half);
		serialPortClock = 1'b1;
		tk(half);
		sdaM = 1'b0;
		tk(half);
		serialPortClock = 1'b0;
	endtask
	task automatic i2cSp();
		tk(half / 2);
		sdaM = 1'b0;
		tk(half / 2);
		serialPortClock = 1'b1;
		tk(half);
		sdaM = 1'b1; // data rises while clock high
		tk(half);
	endtask
	// byte msb first plus acknowledge slot; reports {ack level, byte on wire}
	task automatic i2cByte(input logic [7:0] o, input logic mAck);
		logic [7:0] r;
		logic s;
		for (int i = 7; i >= 0; i--) begin
			i2cBit(o[i], s);
			r[i] = s;
		end
		i2cBit(mAck, s); // master acks all but the last read byte
		report({s, r});
	endtask
endmodule // host_master

// file: verif/serial_register_access_slave_test.sv
`timescale 1ns/1ps
module serial_register_access_slave_test;
	logic clk;
	logic rst;
	logic cs, scl, sdaIn, sdaOut, sdaOeN, sdoIn, sdoOut, sdoOeN;
	logic autoIncrement, threeWireSelect, i2cOff, gotStb;
	logic [8:0] gotVal;
	logic [8:0] expQ[$];
	logic [31:0] seed;
	logic [7:0] b0, b1, b2, aw;
	int fails;
	int checksDone;
	int cyc;
	serial_register_access_slave i_serial_register_access_slave (.clk(clk), .rst(rst),
		.ce(1'b1), .chipSelect(cs), .serialPortClock(scl), .dataPinIn(sdaIn),
		.dataPinOut(sdaOut), .dataPinOeN(sdaOeN), .dataOutOrAddressPinIn(sdoIn),
		.dataOutOrAddressPinOut(sdoOut), .dataOutOrAddressPinOeN(sdoOeN),
		.autoIncrement(autoIncrement), .threeWireSelect(threeWireSelect), .i2cOff(i2cOff));
	host_master i_host_master (.clk(clk), .dataPinOut(sdaOut), .dataPinOeN(sdaOeN),
		.dataOutOrAddressPinOut(sdoOut), .dataOutOrAddressPinOeN(sdoOeN), .chipSelect(cs),
		.serialPortClock(scl), .dataPinIn(sdaIn), .dataOutOrAddressPinIn(sdoIn),
		.gotStb(gotStb), .gotVal(gotVal));
	initial clk = 1'b0;
	always #20 clk = ~clk;
	task automatic complete_run();
		if (fails == 0 && checksDone > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// whole run needs roughly 22k cycles; close to three times that means a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			complete_run();
		end
	end
	// oldest noted expectation against each reported byte
	always @(posedge clk) begin
		if (gotStb === 1'b1) check(gotVal, expQ.pop_front());
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// pins released, then the three control levels
	task automatic ctl(input logic [4:0] e);
		check({4'h0, sdaOeN, sdoOeN, autoIncrement, threeWireSelect, i2cOff},
			{4'h0, e});
	endtask
	task automatic spiWr(input logic [6:0] a, input logic [7:0] d);
		i_host_master.txQ.push_back(d);
		i_host_master.spi(1'b0, a, 1, 1'b1);
	endtask
	task automatic ib(input logic [7:0] o, input logic mAck, input logic [8:0] e);
		expQ.push_back(e);
		i_host_master.i2cByte(o, mAck);
	endtask
	initial begin
		rst = 1'b1;
		seed = 32'h0000005a;
		fails = 0;
		checksDone = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		ctl(5'h18);
		b0 = rnd();
		b1 = rnd();
		b2 = rnd();
		spiWr(7'h12, 8'h04);
		ctl(5'h1c);
		i_host_master.txQ = '{b0, b1, b2};
		i_host_master.spi(1'b0, 7'h20, 3, 1'b0); // mode 0 burst write
		expQ.push_back({1'b0, b0});
		expQ.push_back({1'b0, b1});
		expQ.push_back({1'b0, b2});
		i_host_master.spi(1'b1, 7'h20, 3, 1'b1); // advancing read
		// random strap level picks the address bit
		i_host_master.adrLevel = b2[0];
		aw = {6'h35, b2[0], 1'b0};
		i_host_master.half = 32; // fast mode near 390 kHz
		i_host_master.i2cSt();
		ib(aw, 1'b1, {1'b0, aw});
		ib(8'h30, 1'b1, 9'h030);
		ib(b1, 1'b1, {1'b0, b1});
		ib(b0, 1'b1, {1'b0, b0});
		i_host_master.i2cSp();
		i_host_master.half = 125; // standard mode 100 kHz
		i_host_master.i2cSt();
		ib(aw, 1'b1, {1'b0, aw});
		ib(8'h30, 1'b1, 9'h030);
		i_host_master.i2cSt();
		ib(aw | 8'h01, 1'b1, {1'b0, aw | 8'h01});
		ib(8'hff, 1'b0, {1'b0, b1});
		ib(8'hff, 1'b1, {1'b1, b0});
		i_host_master.i2cSp();
		i_host_master.i2cSt();
		ib(aw ^ 8'h02, 1'b1, {1'b1, aw ^ 8'h02}); // other address left high
		i_host_master.i2cSp();
		spiWr(7'h12, 8'h00);
		expQ.push_back({1'b0, b0});
		expQ.push_back({1'b0, b0});
		i_host_master.spi(1'b1, 7'h20, 2, 1'b0); // same address repeated
		spiWr(7'h12, 8'h08);
		ctl(5'h1a);
		i_host_master.threeWire = 1'b1;
		expQ.push_back({1'b0, b1});
		i_host_master.spi(1'b1, 7'h30, 1, 1'b1); // read data on the shared line
		i_host_master.threeWire = 1'b0;
		spiWr(7'h13, 8'h04);
		ctl(5'h1b);
		i_host_master.i2cSt();
		ib(aw, 1'b1, {1'b1, aw}); // own address ignored while switched off
		i_host_master.i2cSp();
		ctl(5'h1b);
		complete_run();
	end
endmodule // serial_register_access_slave_test
